//--- include/i2csr_pkg.sv
package i2csr_pkg;

  // Own secondary address, chosen by the address select pin.
  localparam logic [6:0] ADDR_SEL_LOW  = 7'h18;
  localparam logic [6:0] ADDR_SEL_HIGH = 7'h19;

  // Direction flag in the eighth bit of the address byte.
  localparam logic DIR_WRITE = 1'h0;
  localparam logic DIR_READ  = 1'h1;

  // Bits per byte; the acknowledge slot follows the last of them.
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Levels of a line that is released or pulled low.
  localparam logic LINE_HIGH = 1'h1;
  localparam logic LINE_LOW  = 1'h0;

  // Register space behind the port.
  localparam int unsigned REG_COUNT = 256;
  localparam logic [7:0]  PTR_RESET = 8'h00;
  localparam logic [7:0]  REG_RESET = 8'h00;

  // Clock periods of both ends, in ns.
  localparam int unsigned REF_CLK_NS  = 50;
  localparam int unsigned LINK_CLK_NS = 64;

  // Longest clock stretch, rounded down to whole link clock cycles.
  localparam int unsigned STRETCH_MAX_NS  = 1000;
  localparam int unsigned STRETCH_MAX_CYC = STRETCH_MAX_NS / LINK_CLK_NS;
  localparam int unsigned STRETCH_CYC     = 4;

  // Serial clock rate made by the primary, as quarter periods of ref_clk.
  localparam int unsigned SCL_KHZ     = 100;
  localparam int unsigned QUARTER_CYC =
    1000000 / (SCL_KHZ * 4 * REF_CLK_NS);

endpackage

//--- include/i2csr_if.sv
`timescale 1ns/10ps
interface i2csr_if;

  logic host_scl_out;
  logic host_scl_oe;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_scl_out;
  logic dev_scl_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups: any enabled low driver wins.
  assign scl = !(host_scl_oe && !host_scl_out) &&
               !(dev_scl_oe && !dev_scl_out);
  assign sda = !(host_sda_oe && !host_sda_out) &&
               !(dev_sda_oe && !dev_sda_out);

  modport host (
    output host_scl_out,
    output host_scl_oe,
    output host_sda_out,
    output host_sda_oe,
    input  scl,
    input  sda
  );

  modport device (
    output dev_scl_out,
    output dev_scl_oe,
    output dev_sda_out,
    output dev_sda_oe,
    input  scl,
    input  sda
  );

endinterface

//--- rtl/i2csr_host.sv
`timescale 1ns/10ps
module i2csr_host #(
  parameter int unsigned QUARTER_CYCLES = i2csr_pkg::QUARTER_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  i2csr_if.host           bus,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic [6:0] cmd_dev_addr,
  input  wire logic [7:0] cmd_reg_addr,
  output logic            cmd_ready,
  input  wire logic [7:0] data_in,
  input  wire logic       data_last,
  output logic            data_take,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            done,
  output logic            ack_error
);

  typedef enum logic [2:0] {
    H_IDLE, H_START, H_BIT, H_RSTART, H_STOP
  } i2csr_hstate_e;
  typedef enum logic [2:0] {
    P_ADDR_W, P_REG, P_WDATA, P_ADDR_R, P_RDATA
  } i2csr_phase_e;

  if (QUARTER_CYCLES < 8 || QUARTER_CYCLES > 65535) begin : g_bad_quarter
    $error("QUARTER_CYCLES must lie between 8 and 65535");
  end

  i2csr_hstate_e state;
  i2csr_phase_e  phase;
  logic [1:0]    q;
  logic [15:0]   div;
  logic          tick;
  logic          stall;
  logic          scl_oe;
  logic          sda_oe;
  logic [8:0]    shreg;
  logic [7:0]    rx;
  logic [8:0]    rx_now;
  logic [3:0]    bitcnt;
  logic          last_q;
  logic          is_read;
  logic [6:0]    dev;
  logic [7:0]    reg_a;
  logic          scl_meta;
  logic          scl_sync;
  logic          sda_meta;
  logic          sda_sync;

  ////////////////////////////////////////////////////////////////////////////

  assign bus.host_scl_out = i2csr_pkg::LINE_LOW;
  assign bus.host_sda_out = i2csr_pkg::LINE_LOW;
  assign bus.host_scl_oe  = scl_oe;
  assign bus.host_sda_oe  = sda_oe;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      scl_meta <= i2csr_pkg::LINE_HIGH;
      scl_sync <= i2csr_pkg::LINE_HIGH;
      sda_meta <= i2csr_pkg::LINE_HIGH;
      sda_sync <= i2csr_pkg::LINE_HIGH;
    end else begin
      scl_meta <= bus.scl;
      scl_sync <= scl_meta;
      sda_meta <= bus.sda;
      sda_sync <= sda_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // A released clock that still reads low is a stretch by the secondary.
  assign stall  = !scl_oe && !scl_sync;
  assign tick   = !stall && (div == 16'(QUARTER_CYCLES - 1));
  assign rx_now = {rx, sda_sync};

  always_ff @(posedge ref_clk) begin
    if (!reset_n || state == H_IDLE || stall || tick) begin
      div <= 16'h0000;
    end else begin
      div <= div + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state     <= H_IDLE;
      phase     <= P_ADDR_W;
      q         <= 2'h0;
      scl_oe    <= 1'h0;
      sda_oe    <= 1'h0;
      shreg     <= 9'h1ff;
      rx        <= 8'h00;
      bitcnt    <= 4'h0;
      last_q    <= 1'h0;
      is_read   <= 1'h0;
      dev       <= 7'h00;
      reg_a     <= 8'h00;
      cmd_ready <= 1'h1;
      data_take <= 1'h0;
      rd_data   <= 8'h00;
      rd_valid  <= 1'h0;
      done      <= 1'h0;
      ack_error <= 1'h0;
    end else begin
      data_take <= 1'h0;
      rd_valid  <= 1'h0;
      done      <= 1'h0;
      unique case (state)
        H_IDLE: begin
          // Both lines stay released while idle.
          if (cmd_valid) begin
            state     <= H_START;
            q         <= 2'h0;
            cmd_ready <= 1'h0;
            ack_error <= 1'h0;
            is_read   <= cmd_read;
            dev       <= cmd_dev_addr;
            reg_a     <= cmd_reg_addr;
          end
        end
        H_START: if (tick) begin
          q <= q + 2'h1;
          unique case (q)
            2'h0: sda_oe <= 1'h1;
            2'h1: ;
            2'h2: scl_oe <= 1'h1;
            2'h3: begin
              state  <= H_BIT;
              phase  <= P_ADDR_W;
              bitcnt <= 4'h0;
              shreg  <= {dev, i2csr_pkg::DIR_WRITE, 1'h1};
            end
          endcase
        end
        H_BIT: if (tick) begin
          q <= q + 2'h1;
          unique case (q)
            2'h0: sda_oe <= !shreg[8];
            2'h1: scl_oe <= 1'h0;
            2'h2: ;
            2'h3: begin
              scl_oe <= 1'h1;
              rx     <= rx_now[7:0];
              shreg  <= {shreg[7:0], 1'h1};
              if (bitcnt != i2csr_pkg::BYTE_BITS) begin
                bitcnt <= bitcnt + 4'h1;
              end else begin
                // Ninth pulse done: the acknowledge bit is sda_sync.
                bitcnt <= 4'h0;
                if (phase != P_RDATA && sda_sync) begin
                  ack_error <= 1'h1;
                  state     <= H_STOP;
                  sda_oe    <= 1'h1;
                end else begin
                  unique case (phase)
                    P_ADDR_W: begin
                      phase <= P_REG;
                      shreg <= {reg_a, 1'h1};
                    end
                    P_REG: begin
                      if (is_read) begin
                        state  <= H_RSTART;
                        sda_oe <= 1'h0;
                      end else begin
                        phase     <= P_WDATA;
                        shreg     <= {data_in, 1'h1};
                        last_q    <= data_last;
                        data_take <= 1'h1;
                      end
                    end
                    P_WDATA: begin
                      if (last_q) begin
                        state  <= H_STOP;
                        sda_oe <= 1'h1;
                      end else begin
                        shreg     <= {data_in, 1'h1};
                        last_q    <= data_last;
                        data_take <= 1'h1;
                      end
                    end
                    P_ADDR_R, P_RDATA: begin
                      if (phase == P_RDATA) begin
                        rd_data  <= rx_now[8:1];
                        rd_valid <= 1'h1;
                      end
                      if (phase == P_RDATA && last_q) begin
                        state  <= H_STOP;
                        sda_oe <= 1'h1;
                      end else begin
                        phase     <= P_RDATA;
                        shreg     <= {8'hff, data_last};
                        last_q    <= data_last;
                        data_take <= 1'h1;
                      end
                    end
                  endcase
                end
              end
            end
          endcase
        end
        H_RSTART: if (tick) begin
          q <= q + 2'h1;
          unique case (q)
            2'h0: scl_oe <= 1'h0;
            2'h1: sda_oe <= 1'h1;
            2'h2: scl_oe <= 1'h1;
            2'h3: begin
              state <= H_BIT;
              phase <= P_ADDR_R;
              shreg <= {dev, i2csr_pkg::DIR_READ, 1'h1};
            end
          endcase
        end
        H_STOP: if (tick) begin
          q <= q + 2'h1;
          unique case (q)
            2'h0: scl_oe <= 1'h0;
            2'h1: ;
            2'h2: sda_oe <= 1'h0;
            2'h3: begin
              state     <= H_IDLE;
              done      <= 1'h1;
              cmd_ready <= 1'h1;
            end
          endcase
        end
      endcase
    end
  end

endmodule

//--- rtl/i2csr_device.sv
`timescale 1ns/10ps
module i2csr_device #(
  parameter int unsigned STRETCH_CYCLES = i2csr_pkg::STRETCH_CYC
) (
  input  wire logic  link_clk,
  input  wire logic  link_reset_n,
  i2csr_if.device    bus,
  input  wire logic  address_select_pin,
  output logic       wr_strobe,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic       bus_busy,
  output logic       addressed
);

  typedef enum logic [2:0] {
    D_IDLE, D_RECV, D_ACK, D_SEND, D_MACK, D_STRETCH, D_IGNORE
  } i2csr_dstate_e;

  typedef enum logic [1:0] {K_ADDR, K_REG, K_DATA} i2csr_kind_e;

  if (STRETCH_CYCLES < 1 ||
      STRETCH_CYCLES > i2csr_pkg::STRETCH_MAX_CYC) begin : g_bad_stretch
    $error("STRETCH_CYCLES must lie between 1 and STRETCH_MAX_CYC");
  end

  i2csr_dstate_e state;
  i2csr_kind_e   kind;
  logic [3:0]    cnt;
  logic [3:0]    stretch_cnt;
  logic [7:0]    shreg;
  logic [7:0]    ptr;
  logic          rd_mode;
  logic          mack;
  logic          scl_oe;
  logic          sda_oe;
  logic          scl_meta;
  logic          scl_sync;
  logic          scl_prev;
  logic          sda_meta;
  logic          sda_sync;
  logic          sda_prev;
  logic          sel_meta;
  logic          sel_sync;
  logic          start_seen;
  logic          stop_seen;
  logic          scl_rise;
  logic          scl_fall;
  logic          byte_in;
  logic          data_commit;
  logic [6:0]    own_addr;
  logic [7:0]    regs [i2csr_pkg::REG_COUNT];

  ////////////////////////////////////////////////////////////////////////////

  // The pads are only ever pulled low; the high level comes from pull-ups.
  assign bus.dev_scl_out = i2csr_pkg::LINE_LOW;
  assign bus.dev_sda_out = i2csr_pkg::LINE_LOW;
  assign bus.dev_scl_oe  = scl_oe;
  assign bus.dev_sda_oe  = sda_oe;

  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      scl_meta <= i2csr_pkg::LINE_HIGH;
      scl_sync <= i2csr_pkg::LINE_HIGH;
      scl_prev <= i2csr_pkg::LINE_HIGH;
      sda_meta <= i2csr_pkg::LINE_HIGH;
      sda_sync <= i2csr_pkg::LINE_HIGH;
      sda_prev <= i2csr_pkg::LINE_HIGH;
      sel_meta <= 1'h0;
      sel_sync <= 1'h0;
    end else begin
      scl_meta <= bus.scl;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= bus.sda;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
      sel_meta <= address_select_pin;
      sel_sync <= sel_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Both lines pass the same synchroniser depth, so their order is kept.
  assign start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_seen  = scl_sync && scl_prev && !sda_prev && sda_sync;
  assign scl_rise   = scl_sync && !scl_prev;
  assign scl_fall   = !scl_sync && scl_prev;
  assign byte_in    = scl_fall && (cnt == i2csr_pkg::BYTE_BITS);
  assign own_addr   = sel_sync ? i2csr_pkg::ADDR_SEL_HIGH
                               : i2csr_pkg::ADDR_SEL_LOW;
  assign data_commit = !start_seen && !stop_seen && state == D_RECV &&
                       kind == K_DATA && byte_in;

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      for (int i = 0; i < i2csr_pkg::REG_COUNT; i++) begin
        regs[i] <= i2csr_pkg::REG_RESET;
      end
    end else if (data_commit) begin
      regs[ptr] <= shreg;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      wr_strobe <= 1'h0;
      wr_addr   <= i2csr_pkg::PTR_RESET;
      wr_data   <= i2csr_pkg::REG_RESET;
    end else begin
      wr_strobe <= data_commit;
      if (data_commit) begin
        wr_addr <= ptr;
        wr_data <= shreg;
      end
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      bus_busy <= 1'h0;
    end else if (start_seen) begin
      bus_busy <= 1'h1;
    end else if (stop_seen) begin
      bus_busy <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      state       <= D_IDLE;
      kind        <= K_ADDR;
      cnt         <= 4'h0;
      stretch_cnt <= 4'h0;
      shreg       <= 8'h00;
      ptr         <= i2csr_pkg::PTR_RESET;
      rd_mode     <= 1'h0;
      mack        <= 1'h0;
      scl_oe      <= 1'h0;
      sda_oe      <= 1'h0;
      addressed   <= 1'h0;
    end else if (start_seen) begin
      state     <= D_RECV;
      kind      <= K_ADDR;
      cnt       <= 4'h0;
      scl_oe    <= 1'h0;
      sda_oe    <= 1'h0;
      addressed <= 1'h0;
    end else if (stop_seen) begin
      state     <= D_IDLE;
      scl_oe    <= 1'h0;
      sda_oe    <= 1'h0;
      addressed <= 1'h0;
    end else begin
      unique case (state)
        D_IDLE, D_IGNORE: ;
        D_RECV: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_sync};
            cnt   <= cnt + 4'h1;
          end else if (byte_in) begin
            cnt <= 4'h0;
            unique case (kind)
              K_ADDR: begin
                if (shreg[7:1] == own_addr) begin
                  rd_mode   <= shreg[0];
                  addressed <= 1'h1;
                  sda_oe    <= 1'h1;
                  state     <= D_ACK;
                end else begin
                  state <= D_IGNORE;
                end
              end
              K_REG: begin
                ptr    <= shreg;
                sda_oe <= 1'h1;
                state  <= D_ACK;
              end
              K_DATA: begin
                ptr    <= ptr + 8'h01;
                sda_oe <= 1'h1;
                state  <= D_ACK;
              end
            endcase
          end
        end
        D_ACK: if (scl_fall) begin
          // End of the ninth pulse.
          if (kind == K_ADDR && rd_mode == i2csr_pkg::DIR_READ) begin
            shreg  <= regs[ptr];
            sda_oe <= !regs[ptr][7];
            ptr    <= ptr + 8'h01;
            state  <= D_SEND;
          end else begin
            sda_oe <= 1'h0;
            kind   <= (kind == K_ADDR) ? K_REG : K_DATA;
            state  <= D_RECV;
          end
        end
        D_SEND: if (scl_fall) begin
          if (cnt == i2csr_pkg::BYTE_BITS - 4'h1) begin
            cnt    <= 4'h0;
            sda_oe <= 1'h0;
            state  <= D_MACK;
          end else begin
            cnt    <= cnt + 4'h1;
            shreg  <= {shreg[6:0], 1'h0};
            sda_oe <= !shreg[6];
          end
        end
        D_MACK: begin
          if (scl_rise) begin
            mack <= !sda_sync;
          end else if (scl_fall) begin
            if (mack) begin
              // The next byte is put on the wire while the clock is held,
              // so no data edge can meet the released clock.
              scl_oe      <= 1'h1;
              stretch_cnt <= 4'h0;
              shreg       <= regs[ptr];
              sda_oe      <= !regs[ptr][7];
              ptr         <= ptr + 8'h01;
              state       <= D_STRETCH;
            end else begin
              state <= D_IGNORE;
            end
          end
        end
        D_STRETCH: begin
          if (stretch_cnt == 4'(STRETCH_CYCLES - 1)) begin
            scl_oe <= 1'h0;
            state  <= D_SEND;
          end else begin
            stretch_cnt <= stretch_cnt + 4'h1;
          end
        end
      endcase
    end
  end

endmodule

//--- tb/i2csr_sva.sv
`timescale 1ns/10ps
module i2csr_sva (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic link_reset_n,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic sda_r;
  logic busy_r;
  logic sda_l;
  logic busy_l;
  // Each domain tracks start and stop on its own samples of the raw wires.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sda_r  <= 1'h1;
      busy_r <= 1'h0;
    end else begin
      sda_r  <= sda;
      busy_r <= scl && sda_r != sda ? sda_r : busy_r;
    end
  end
  always_ff @(posedge link_clk) begin
    if (!link_reset_n) begin
      sda_l  <= 1'h1;
      busy_l <= 1'h0;
    end else begin
      sda_l  <= sda;
      busy_l <= scl && sda_l != sda ? sda_l : busy_l;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_host_idle_free : assert property (
    @(posedge ref_clk) disable iff (!reset_n) !busy_r |-> !host_scl_oe)
    else $error("host pulls clock on idle bus");
  a_dev_idle_free : assert property (
    @(posedge link_clk) disable iff (!link_reset_n)
    !busy_l |-> !dev_sda_oe && !dev_scl_oe)
    else $error("device drives idle bus");
  a_dev_sda_steady : assert property (
    @(posedge link_clk) disable iff (!link_reset_n)
    scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device data moved while clock high");
  a_stretch_bound : assert property (
    @(posedge link_clk) disable iff (!link_reset_n)
    $rose(dev_scl_oe) |-> ##[1:15] !dev_scl_oe)
    else $error("clock stretch too long");
  a_stretch_in_low : assert property (
    @(posedge link_clk) disable iff (!link_reset_n)
    $rose(dev_scl_oe) |-> !$past(scl))
    else $error("stretch began with clock high");
  a_host_waits : assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    busy_r && !host_scl_oe && !scl |=> !host_scl_oe && $stable(host_sda_oe))
    else $error("host moved during stretch");
  a_one_driver_high : assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(scl) && dev_sda_oe |-> !host_sda_oe)
    else $error("both ends drive data");
  a_dev_quiet_stop : assert property (
    @(posedge link_clk) disable iff (!link_reset_n)
    scl && $past(scl) && $rose(sda) |-> (!dev_sda_oe && !dev_scl_oe) [*8])
    else $error("device active after stop");
  a_host_quiet_stop : assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    scl && $past(scl) && $rose(sda) |-> !host_scl_oe [*8])
    else $error("host active after stop");
endmodule

//--- tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        ref_clk, link_clk, reset_n, link_reset_n;
  logic        cmd_valid, cmd_read, data_last, address_select_pin;
  logic        cmd_ready, data_take, rd_valid, done, ack_error;
  logic        wr_strobe, bus_busy, addressed;
  logic        seen_addr, seen_hold;
  logic [6:0]  cmd_dev_addr;
  logic [7:0]  cmd_reg_addr, data_in, rd_data, wr_addr, wr_data;
  logic [8:0]  shreg, first_byte;
  logic [15:0] wq[$];
  logic [7:0]  rq[$];
  logic [7:0]  pat[3] = '{8'ha5, 8'h5a, 8'hc3};
  int          n_mismatch = 0, samples_checked = 0, cycles = 0, n_rise = 0;

  i2csr_if bus ();
  i2csr_host #(.QUARTER_CYCLES(8)) i_i2csr_host (.ref_clk(ref_clk),
    .reset_n(reset_n), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_dev_addr(cmd_dev_addr),
    .cmd_reg_addr(cmd_reg_addr), .cmd_ready(cmd_ready), .data_in(data_in),
    .data_last(data_last), .data_take(data_take), .rd_data(rd_data),
    .rd_valid(rd_valid), .done(done), .ack_error(ack_error));
  // The longest stretch outlasts the host's own low phase, so it must wait.
  i2csr_device #(.STRETCH_CYCLES(15)) i_i2csr_device (.link_clk(link_clk),
    .link_reset_n(link_reset_n), .bus(bus),
    .address_select_pin(address_select_pin), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data), .bus_busy(bus_busy),
    .addressed(addressed));
  i2csr_sva i_sva (.ref_clk(ref_clk), .reset_n(reset_n),
    .link_clk(link_clk), .link_reset_n(link_reset_n),
    .host_scl_oe(bus.host_scl_oe), .host_sda_oe(bus.host_sda_oe),
    .dev_scl_oe(bus.dev_scl_oe), .dev_sda_oe(bus.dev_sda_oe),
    .scl(bus.scl), .sda(bus.sda));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  // The offset moves the link edges off the reference edges at start; they still meet every 800 ns.
  initial begin
    link_clk = 1'h0;
    #7;
    forever #32 link_clk = ~link_clk;
  end
  always @(posedge bus.scl) begin
    n_rise++;
    shreg = {shreg[7:0], bus.sda};
    if (n_rise == 9) first_byte = shreg;
  end
  always @(negedge link_clk) begin
    if (wr_strobe === 1'h1) wq.push_back({wr_addr, wr_data});
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Data moves one cycle after the take pulse so the host samples it whole.
  task automatic run(input logic rd, input logic [6:0] da,
                     input logic [7:0] ra, input int n, input int rises);
    int   k;
    int   t;
    logic took;
    logic seen_busy;
    k = 0;
    took = 1'h0;
    seen_busy = 1'h0;
    seen_addr = 1'h0;
    seen_hold = 1'h0;
    wq.delete();
    rq.delete();
    @(negedge ref_clk);
    n_rise = 0;
    cmd_read = rd;
    cmd_dev_addr = da;
    cmd_reg_addr = ra;
    data_in = pat[0];
    data_last = n == 1;
    cmd_valid = 1'h1;
    @(negedge ref_clk);
    cmd_valid = 1'h0;
    check(cmd_ready, 1'h0);
    for (t = 0; t < 20000 && done !== 1'h1; t++) begin
      @(negedge ref_clk);
      if (took) begin
        k++;
        data_in = pat[k % 3];
        data_last = k == n - 1;
        took = 1'h0;
      end
      if (data_take === 1'h1) took = 1'h1;
      if (rd_valid === 1'h1) rq.push_back(rd_data);
      if (bus_busy === 1'h1) seen_busy = 1'h1;
      if (addressed === 1'h1) seen_addr = 1'h1;
      if (bus.dev_scl_oe === 1'h1 && bus.host_scl_oe === 1'h0)
        seen_hold = 1'h1;
    end
    check(done, 1'h1);
    repeat (8) @(negedge ref_clk);
    check(seen_busy, 1'h1);
    check(cmd_ready, 1'h1);
    check(addressed, 1'h0);
    check(bus_busy, 1'h0);
    check({bus.scl, bus.sda}, 2'h3);
    check(n_rise, rises);
  endtask

  task automatic t_write;
    int i;
    run(1'h0, 7'h18, 8'h10, 3, 46);
    check(first_byte, {7'h18, 2'h0});
    check(seen_addr, 1'h1);
    check(seen_hold, 1'h0);
    check(ack_error, 1'h0);
    check(wq.size(), 3);
    for (i = 0; i < 3; i++) check(wq[i], {8'h10 + 8'(i), pat[i]});
    $display("burst write test ended");
  endtask

  task automatic t_read;
    int i;
    run(1'h1, 7'h18, 8'h10, 3, 56);
    check(ack_error, 1'h0);
    check(rq.size(), 3);
    check(seen_hold, 1'h1);
    for (i = 0; i < 3; i++) check(rq[i], pat[i]);
    run(1'h1, 7'h18, 8'h12, 1, 38);
    check(rq.size(), 1);
    check(seen_hold, 1'h0);
    check(rq[0], 8'hc3);
    $display("read test ended");
  endtask

  task automatic t_addr;
    int   j;
    logic hit;
    for (j = 0; j < 4; j++) begin
      @(negedge ref_clk);
      address_select_pin = j[1];
      repeat (8) @(negedge ref_clk);
      hit = j[1] == j[0];
      run(1'h0, 7'h18 + 7'(j[0]), 8'h20 + 8'(j), 1, hit ? 28 : 10);
      check(ack_error, !hit);
      check(seen_addr, hit);
      check(wq.size(), hit);
      if (hit) check(wq[0], {8'h20 + 8'(j), 8'ha5});
    end
    $display("address select test ended");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'h0;
    link_reset_n = 1'h0;
    cmd_valid = 1'h0;
    cmd_read = 1'h0;
    cmd_dev_addr = 7'h00;
    cmd_reg_addr = 8'h00;
    data_in = 8'h00;
    data_last = 1'h0;
    address_select_pin = 1'h0;
    repeat (6) @(negedge ref_clk);
    reset_n = 1'h1;
    link_reset_n = 1'h1;
    repeat (10) @(negedge ref_clk);
    t_write();
    t_read();
    t_addr();
    print_verdict();
  end
endmodule
